//--- verilog/ppsel_pkg.sv
// Package for the P/PI mode switch selector: register map, fields, resets
package ppsel_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] PPSEL_OFF_CTRL = 8'h00;
  localparam logic [7:0] PPSEL_OFF_TRQ_LVL = 8'h04;
  localparam logic [7:0] PPSEL_OFF_SPD_LVL = 8'h08;
  localparam logic [7:0] PPSEL_OFF_ACC_LVL = 8'h0c;
  localparam logic [7:0] PPSEL_OFF_PERR_LVL = 8'h10;
  localparam logic [7:0] PPSEL_OFF_STATUS = 8'h14;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int PPSEL_CTRL_COND_LSB = 0;
  localparam int PPSEL_CTRL_METHOD_LSB = 4;

  // ----------------------------------------
  // Control method codes
  // ----------------------------------------
  localparam logic [3:0] PPSEL_METH_SPEED = 4'h0;
  localparam logic [3:0] PPSEL_METH_POSITION = 4'h1;
  localparam logic [3:0] PPSEL_METH_TORQUE = 4'h2;
  localparam logic [3:0] PPSEL_METH_SPD_ZCLAMP = 4'ha;
  localparam logic [3:0] PPSEL_METH_POS_INHIBIT = 4'hb;

  // ----------------------------------------
  // Mode switch condition codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PPSEL_COND_TORQUE = 3'b000,
    PPSEL_COND_SPEED = 3'b001,
    PPSEL_COND_ACCEL = 3'b010,
    PPSEL_COND_PERR = 3'b011,
    PPSEL_COND_OFF = 3'b100
  } ppsel_cond_type;

  // ----------------------------------------
  // Reset values and ranges
  // ----------------------------------------
  localparam logic [3:0] PPSEL_METHOD_RST = 4'h0;
  localparam logic [2:0] PPSEL_COND_RST = 3'h0;
  localparam logic [15:0] PPSEL_TRQ_LVL_RST = 16'h00c8;
  localparam logic [15:0] PPSEL_SPD_LVL_RST = 16'h0000;
  localparam logic [15:0] PPSEL_ACC_LVL_RST = 16'h0000;
  localparam logic [15:0] PPSEL_PERR_LVL_RST = 16'h0000;
  localparam logic [15:0] PPSEL_TRQ_LVL_MAX = 16'h0320;
  localparam logic [15:0] PPSEL_SPD_LVL_MAX = 16'h2710;
  localparam logic [15:0] PPSEL_ACC_LVL_MAX = 16'h7530;
  localparam logic [15:0] PPSEL_PERR_LVL_MAX = 16'h2710;

  // ----------------------------------------
  // AXI responses
  // ----------------------------------------
  localparam logic [1:0] PPSEL_RESP_OKAY = 2'b00;
  localparam logic [1:0] PPSEL_RESP_SLVERR = 2'b10;

endpackage : ppsel_pkg

//--- verilog/ppsel_top.sv
// P/PI mode switch selector for the speed loop, with AXI4-Lite registers
//
// Behaviour
// (RULE_01) Proportional-only allowed only while active method is speed or position control.
// (RULE_02) Method 0 speed (default), 1 position; external select may force P there.
// (RULE_03) Method 2 torque control ignores every request for proportional-only.
// (RULE_04) Method A speed/zero-clamp and B position/pulse-inhibit are also encoded.
// (RULE_05) Condition 0 torque, 1 speed, 2 accel, 3 position error, own thresholds.
// (RULE_06) Condition 4 disables automatic mode switching entirely.
// (RULE_07) Torque mode: P when torque reference exceeds threshold, 0-800 %, default 200.
// (RULE_08) Speed mode: P when speed reference exceeds threshold, 0-10000, default 0.
// (RULE_09) Accel mode: P when acceleration exceeds threshold, 0-30000, default 0.
// (RULE_10) Position error mode: P when error exceeds threshold, 0-10000, default 0.
// (RULE_11) Position error condition acts only in position control.
// (RULE_12) Select input low requests P, high requests PI; honoured where allowed.
// (RULE_13) P when permitted select or automatic condition asks; re-evaluated every cycle.
// (RULE_14) Absolute magnitude compared, so either sign switches symmetrically.
`timescale 1ns/1ps

module ppsel_top
  import ppsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Host select, active low
  input wire logic proportional_select_input_n,
  // Signed loop quantities, sampled every cycle
  input wire logic signed [15:0] torque_ref,
  input wire logic signed [15:0] speed_ref,
  input wire logic signed [15:0] accel_ref,
  input wire logic signed [31:0] position_error,
  // Loop mode out: high for proportional-only
  output logic p_control_q
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] control_method_select_q;
  logic [2:0] mode_switch_condition_select_q;
  logic [15:0] torque_switch_level_q;
  logic [15:0] speed_switch_level_q;
  logic [15:0] accel_switch_level_q;
  logic [15:0] position_error_switch_level_q;
  logic auto_req_q;
  logic ext_req_q;

  // ----------------------------------------
  // AXI write path
  // ----------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic [1:0] wr_resp;
  logic aw_held_d;
  logic w_held_d;
  logic bvalid_d;

  assign do_write = aw_held_q && w_held_q;

  // Next values of the hold flags and of the response valid
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    bvalid_d = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
    end else if (do_write) begin
      aw_held_d = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
    end else if (do_write) begin
      w_held_d = 1'b0;
    end
    if (do_write) begin
      bvalid_d = 1'b1;
    end else if (s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // Address and data captured in either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  always_comb begin
    unique case (aw_addr_q)
      PPSEL_OFF_CTRL, PPSEL_OFF_TRQ_LVL, PPSEL_OFF_SPD_LVL,
      PPSEL_OFF_ACC_LVL, PPSEL_OFF_PERR_LVL: wr_resp = PPSEL_RESP_OKAY;
      default: wr_resp = PPSEL_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PPSEL_RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_d;
      if (do_write) begin
        s_axi_bresp <= wr_resp;
      end
    end
  end

  // Readies from flops, loaded with what a gate on the next flop state would show
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready <= !w_held_d && !bvalid_d;
    end
  end

  // Clamp a written level to its documented range; out-of-range writes saturate
  function automatic logic [15:0] clamp_level(input logic [15:0] v, input logic [15:0] mx);
    clamp_level = (v > mx) ? mx : v;
  endfunction : clamp_level

  // Configuration registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_method_select_q <= PPSEL_METHOD_RST;
      mode_switch_condition_select_q <= PPSEL_COND_RST;
      torque_switch_level_q <= PPSEL_TRQ_LVL_RST;
      speed_switch_level_q <= PPSEL_SPD_LVL_RST;
      accel_switch_level_q <= PPSEL_ACC_LVL_RST;
      position_error_switch_level_q <= PPSEL_PERR_LVL_RST;
    end else if (do_write) begin
      unique case (aw_addr_q)
        PPSEL_OFF_CTRL: begin
          if (w_strb_q[0]) begin
            mode_switch_condition_select_q <= w_data_q[PPSEL_CTRL_COND_LSB +: 3];
            // (RULE_04) Full method code kept
            control_method_select_q <= w_data_q[PPSEL_CTRL_METHOD_LSB +: 4];
          end
        end
        PPSEL_OFF_TRQ_LVL: begin
          // (RULE_07) Torque level range
          if (&w_strb_q[1:0]) torque_switch_level_q <= clamp_level(w_data_q[15:0], PPSEL_TRQ_LVL_MAX);
        end
        PPSEL_OFF_SPD_LVL: begin
          // (RULE_08) Speed level range
          if (&w_strb_q[1:0]) speed_switch_level_q <= clamp_level(w_data_q[15:0], PPSEL_SPD_LVL_MAX);
        end
        PPSEL_OFF_ACC_LVL: begin
          // (RULE_09) Accel level range
          if (&w_strb_q[1:0]) accel_switch_level_q <= clamp_level(w_data_q[15:0], PPSEL_ACC_LVL_MAX);
        end
        PPSEL_OFF_PERR_LVL: begin
          // (RULE_10) Error level range
          if (&w_strb_q[1:0]) begin
            position_error_switch_level_q <= clamp_level(w_data_q[15:0], PPSEL_PERR_LVL_MAX);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // AXI read path
  // ----------------------------------------
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic rvalid_d;

  // Next value of the read valid
  always_comb begin
    rvalid_d = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
    end else if (s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = PPSEL_RESP_OKAY;
    unique case (s_axi_araddr)
      PPSEL_OFF_CTRL: rd_data = {24'h00_0000, control_method_select_q, 1'b0, mode_switch_condition_select_q};
      PPSEL_OFF_TRQ_LVL: rd_data = {16'h0000, torque_switch_level_q};
      PPSEL_OFF_SPD_LVL: rd_data = {16'h0000, speed_switch_level_q};
      PPSEL_OFF_ACC_LVL: rd_data = {16'h0000, accel_switch_level_q};
      PPSEL_OFF_PERR_LVL: rd_data = {16'h0000, position_error_switch_level_q};
      PPSEL_OFF_STATUS: rd_data = {29'h0000_0000, auto_req_q, ext_req_q, p_control_q};
      default: rd_resp = PPSEL_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PPSEL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Read ready from a flop; one read at a time, so it falls with every accepted address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !rvalid_d;
    end
  end

  // ----------------------------------------
  // Method decode
  // ----------------------------------------
  logic method_speed;
  logic method_position;
  logic p_permitted;

  // (RULE_02) Speed and position codes
  assign method_speed = (control_method_select_q == PPSEL_METH_SPEED);
  assign method_position = (control_method_select_q == PPSEL_METH_POSITION);
  // (RULE_01) Only speed or position; torque and combos excluded
  // (RULE_03) Torque blocks P requests
  assign p_permitted = method_speed || method_position;

  // ----------------------------------------
  // Magnitudes and comparison
  // ----------------------------------------
  logic [15:0] trq_mag;
  logic [15:0] spd_mag;
  logic [15:0] acc_mag;
  logic [31:0] perr_mag;
  logic auto_hit;

  // (RULE_14) Absolute values; the most negative code wraps to its own magnitude
  ppsel_abs_mag #(.WIDTH(16)) u_trq_mag (.value(torque_ref), .mag(trq_mag));
  ppsel_abs_mag #(.WIDTH(16)) u_spd_mag (.value(speed_ref), .mag(spd_mag));
  ppsel_abs_mag #(.WIDTH(16)) u_acc_mag (.value(accel_ref), .mag(acc_mag));
  ppsel_abs_mag #(.WIDTH(32)) u_perr_mag (.value(position_error), .mag(perr_mag));

  always_comb begin
    auto_hit = 1'b0;
    // (RULE_05) Source select per condition
    unique case (mode_switch_condition_select_q)
      // (RULE_07) Torque exceeds level
      PPSEL_COND_TORQUE: auto_hit = trq_mag > torque_switch_level_q;
      // (RULE_08) Speed exceeds level
      PPSEL_COND_SPEED: auto_hit = spd_mag > speed_switch_level_q;
      // (RULE_09) Accel exceeds level
      PPSEL_COND_ACCEL: auto_hit = acc_mag > accel_switch_level_q;
      // (RULE_10) Error exceeds level
      // (RULE_11) Position control only
      PPSEL_COND_PERR: auto_hit = method_position && (perr_mag > {16'h0000, position_error_switch_level_q});
      // (RULE_06) Switch disabled
      PPSEL_COND_OFF: auto_hit = 1'b0;
      default: auto_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Mode output
  // ----------------------------------------
  // (RULE_13) Either request, every cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p_control_q <= 1'b0;
    end else begin
      // (RULE_12) Low level requests P
      p_control_q <= p_permitted && (auto_hit || !proportional_select_input_n);
    end
  end

  // Status copies are registered, so a read shows the same cycle as the mode output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      auto_req_q <= 1'b0;
      ext_req_q <= 1'b0;
    end else begin
      auto_req_q <= auto_hit;
      ext_req_q <= !proportional_select_input_n;
    end
  end

endmodule : ppsel_top

// ----------------------------------------
// Magnitude of a signed loop quantity
// ----------------------------------------
// The most negative code has no positive twin; it wraps to its own bit pattern
module ppsel_abs_mag #(
  parameter int WIDTH = 16
) (
  // Signed value in
  input wire logic signed [WIDTH-1:0] value,
  // Unsigned magnitude out
  output logic [WIDTH-1:0] mag
);

  assign mag = value[WIDTH-1] ? WIDTH'(-value) : WIDTH'(value);

endmodule : ppsel_abs_mag

//--- verification/ppsel_assertions.sv
// Port checker for the P/PI mode switch selector
`timescale 1ns/1ps

module ppsel_checker
  import ppsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register writes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  // Loop side
  input wire logic proportional_select_input_n,
  input wire logic signed [15:0] torque_ref,
  input wire logic p_control_q
);
  // ----------------------------------------
  // Shadow of method and condition
  // ----------------------------------------
  logic [7:0] aw_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic awp_q, wp_q, tw_q;
  logic [3:0] m_q;
  logic [2:0] c_q;
  logic pok, sel_n;
  logic [15:0] tmag;
  // Commit one cycle after both halves are held, the same edge the slave writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awp_q <= 1'b0;
      wp_q <= 1'b0;
      tw_q <= 1'b0;
      m_q <= PPSEL_METHOD_RST;
      c_q <= PPSEL_COND_RST;
    end else begin
      if (awp_q && wp_q) begin
        awp_q <= 1'b0;
        wp_q <= 1'b0;
        if (aw_q == PPSEL_OFF_CTRL && ws_q[0]) begin
          m_q <= wd_q[7:4];
          c_q <= wd_q[2:0];
        end
        if (aw_q == PPSEL_OFF_TRQ_LVL) tw_q <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) awp_q <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) wp_q <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
    if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb;
  end
  assign pok = (m_q == PPSEL_METH_SPEED) || (m_q == PPSEL_METH_POSITION);
  assign sel_n = proportional_select_input_n;
  // Most negative value wraps, as the slave does
  assign tmag = torque_ref[15] ? -torque_ref : torque_ref;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_METHOD_GATE: assert property (!pok |=> !p_control_q)
    else $error("p control with a forbidding method");
  AST_P_NEEDS_METHOD: assert property (p_control_q |-> $past(pok))
    else $error("p control not preceded by speed or position");
  AST_TORQUE_BLOCK: assert property (m_q == PPSEL_METH_TORQUE && !sel_n |=> !p_control_q)
    else $error("torque method took a p request");
  AST_COMBINED_BLOCK: assert property ((m_q == 4'ha || m_q == 4'hb) && !sel_n |=> !p_control_q)
    else $error("combined method took a p request");
  AST_SELECT_P: assert property (pok && !sel_n |=> p_control_q)
    else $error("select low did not give p control");
  AST_AUTO_OFF: assert property (pok && c_q >= 3'd4 |=> p_control_q == !$past(sel_n))
    else $error("disabled switch still acted");
  AST_PERR_ONLY_POS: assert property (m_q == PPSEL_METH_SPEED && c_q == 3'd3 |=> p_control_q == !$past(sel_n))
    else $error("position error acted outside position control");
  AST_TRQ_DEFAULT: assert property (pok && c_q == 3'd0 && sel_n && !tw_q |=> p_control_q == ($past(tmag) > 16'd200))
    else $error("default torque level not applied");
  cover property (pok && !sel_n ##1 p_control_q);
  cover property (m_q == PPSEL_METH_POSITION && c_q == 3'd3 && sel_n ##1 p_control_q);
  cover property (m_q == PPSEL_METH_TORQUE && !sel_n);
endmodule : ppsel_checker

bind ppsel_top ppsel_checker u_ppsel_checker (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .proportional_select_input_n(proportional_select_input_n), .torque_ref(torque_ref), .p_control_q(p_control_q));

//--- verification/ppsel_host_model.sv
// Host controller model: select input and loop references
`timescale 1ns/1ps

module ppsel_host_model (
  // Clock, reset and bench commands
  input wire logic clk,
  input wire logic rstn,
  input wire logic draw,
  input wire logic req_p,
  // Towards the selector
  output logic sel_n_q,
  output logic signed [15:0] trq_q,
  output logic signed [15:0] spd_q,
  output logic signed [15:0] acc_q,
  output logic signed [31:0] perr_q
);
  function automatic int pick();
    int v;
    v = $urandom_range(0, 1200);
    return $urandom_range(0, 1) ? -v : v;
  endfunction : pick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_n_q <= 1'b1;
      trq_q <= 16'h0000;
      spd_q <= 16'h0000;
      acc_q <= 16'h0000;
      perr_q <= 32'h0000_0000;
    end else if (draw) begin
      sel_n_q <= !req_p;
      trq_q <= 16'(pick());
      spd_q <= 16'(pick());
      acc_q <= 16'(pick());
      perr_q <= 32'(pick());
    end
  end
endmodule : ppsel_host_model

//--- verification/p_pi_mode_switch_selector_test.sv
// Self-checking bench for the P/PI mode switch selector
`timescale 1ns/1ps

module p_pi_mode_switch_selector_test
  import ppsel_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, draw = 1'b0, req_p = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, p, sel_n;
  logic [1:0] bresp, rresp, rs;
  logic signed [15:0] trq, spd, acc;
  logic signed [31:0] perr;
  int errors = 0, total_checks = 0;
  int lv[4] = '{200, 0, 0, 0};
  int meth[6] = '{0, 1, 2, 5, 10, 11};

  always #20 clk = ~clk;

  ppsel_top u_ppsel_top (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .proportional_select_input_n(sel_n), .torque_ref(trq),
    .speed_ref(spd), .accel_ref(acc), .position_error(perr), .p_control_q(p));
  ppsel_host_model u_ppsel_host_model (.clk(clk), .rstn(rstn), .draw(draw), .req_p(req_p), .sel_n_q(sel_n),
    .trq_q(trq), .spd_q(spd), .acc_q(acc), .perr_q(perr));

  // ----------------------------------------
  // Bus tasks, model and compare
  // ----------------------------------------
  // Handshakes are read at the falling edge so no race with the slave's flops
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rs = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      ar = arvalid && arready;
      r = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask : axi_read

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  function automatic logic exp_p(input int m, input int c);
    int v[4];
    v = '{int'(trq), int'(spd), int'(acc), int'(perr)};
    foreach (v[i]) if (v[i] < 0) v[i] = -v[i];
    if (m > 1) return 1'b0;
    return !sel_n || (c < 4 && v[c] > lv[c] && (c != 3 || m == 1));
  endfunction : exp_p

  task automatic run_mode(input int m, input int c);
    repeat (8) begin
      @(posedge clk);
      draw <= 1'b1;
      req_p <= 1'($urandom_range(0, 3) == 0);
      @(posedge clk);
      draw <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check("p_control", {31'h0, exp_p(m, c)}, {31'h0, p});
    end
  endtask : run_mode

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Whole run is about two thousand cycles; the limit leaves ample room
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h1d38));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    axi_read(PPSEL_OFF_CTRL);
    check("ctrl", 32'h0, rd);
    axi_read(PPSEL_OFF_TRQ_LVL);
    check("torque_level", 32'd200, rd);
    axi_read(8'h1c);
    check("unmapped_resp", 32'(PPSEL_RESP_SLVERR), 32'(rs));
    run_mode(0, 0);
    $display("test 1 done");
    axi_write(PPSEL_OFF_TRQ_LVL, 32'd900);
    axi_read(PPSEL_OFF_TRQ_LVL);
    check("torque_level_max", 32'd800, rd);
    wstrb <= 4'h2;
    axi_write(PPSEL_OFF_TRQ_LVL, 32'd5);
    wstrb <= 4'hf;
    axi_read(PPSEL_OFF_TRQ_LVL);
    check("torque_level_strb", 32'd800, rd);
    axi_write(PPSEL_OFF_STATUS, 32'h0);
    check("status_wr_resp", 32'(PPSEL_RESP_SLVERR), 32'(rs));
    for (int i = 0; i < 4; i++) begin
      lv[i] = $urandom_range(0, 800);
      axi_write(8'(4 * i + 4), 32'(lv[i]));
    end
    $display("test 2 done");
    foreach (meth[k]) begin
      for (int c = 0; c < 8; c++) begin
        axi_write(PPSEL_OFF_CTRL, 32'(meth[k] * 16 + c));
        check("ctrl_resp", 32'(PPSEL_RESP_OKAY), 32'(rs));
        run_mode(meth[k], c);
        axi_read(PPSEL_OFF_STATUS);
        check("status", {30'h0, !sel_n, exp_p(meth[k], c)}, {30'h0, rd[1:0]});
      end
    end
    $display("test 3 done");
    give_verdict();
  end
endmodule : p_pi_mode_switch_selector_test
